// >>> verilog/jip_pkg.sv
// package: constants for the test-port identification and bypass data path
package jip_pkg;
	// instruction register width and opcodes
	localparam int unsigned IR_W = 4;
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_IDCODE = 4'h1;
	localparam logic [3:0] IR_BYPASS = 4'hF;
	// capture pattern of the instruction register, low bits 01
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// identification register width
	localparam int unsigned ID_W = 32;
	// identification value (arbitrary neutral value)
	localparam logic [31:0] ID_VALUE = 32'h0000_0001;
	// reset values
	localparam logic        TDO_RST = 1'h0;
	localparam logic        BYP_RST = 1'h0;
	localparam logic        OE_RST  = 1'h0;
	localparam logic        SEL_RST = 1'h1;
	localparam logic        TLR_RST = 1'h1;
	// tap controller states
	typedef enum logic [3:0] {
		JIP_RESET, JIP_IDLE, JIP_SEL_DR, JIP_CAP_DR, JIP_SH_DR, JIP_EX1_DR,
		JIP_PAU_DR, JIP_EX2_DR, JIP_UPD_DR, JIP_SEL_IR, JIP_CAP_IR,
		JIP_SH_IR, JIP_EX1_IR, JIP_PAU_IR, JIP_EX2_IR, JIP_UPD_IR
	} jip_state_t;
endpackage

// >>> verilog/jip_tap.sv
// module: boundary-scan tap with identification and bypass data registers
module jip_tap (
	// system
	input  wire logic sys_clk,
	input  wire logic rst,
	// test port pins
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	input  wire logic trst_n,
	output logic      tdo,
	output logic      tdo_oe,
	// status
	output logic      id_sel_r,
	output logic      tlr_r
);
	// three-stage synchronisers for pins
	logic [2:0] tck_s, tms_s, tdi_s, trst_s;
	logic       tck_q, tms_q, tdi_q, trst_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tck_s  <= 3'h0;
			tms_s  <= 3'h7;
			tdi_s  <= 3'h7;
			trst_s <= 3'h7;
		end else begin
			tck_s  <= {tck_s[1:0], tck};
			tms_s  <= {tms_s[1:0], tms};
			tdi_s  <= {tdi_s[1:0], tdi};
			trst_s <= {trst_s[1:0], trst_n};
		end
	end

	// filtered levels: change once stages two and three agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tck_q  <= 1'h0;
			tms_q  <= 1'h1;
			tdi_q  <= 1'h1;
			trst_q <= 1'h1;
		end else begin
			if (tck_s[1] == tck_s[2]) tck_q <= tck_s[2];
			if (tms_s[1] == tms_s[2]) tms_q <= tms_s[2];
			if (tdi_s[1] == tdi_s[2]) tdi_q <= tdi_s[2];
			if (trst_s[1] == trst_s[2]) trst_q <= trst_s[2];
		end
	end

	// test clock edges
	logic rise; // synced test clock went high
	logic fall; // synced test clock went low
	assign rise = (tck_s[1] == tck_s[2]) && tck_s[2] && !tck_q;
	assign fall = (tck_s[1] == tck_s[2]) && !tck_s[2] && tck_q;

	// tap state machine
	jip_pkg::jip_state_t st_r, st_nxt;
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			jip_pkg::JIP_RESET:  st_nxt = tms_q ? jip_pkg::JIP_RESET
			                                    : jip_pkg::JIP_IDLE;
			jip_pkg::JIP_IDLE:   st_nxt = tms_q ? jip_pkg::JIP_SEL_DR
			                                    : jip_pkg::JIP_IDLE;
			jip_pkg::JIP_SEL_DR: st_nxt = tms_q ? jip_pkg::JIP_SEL_IR
			                                    : jip_pkg::JIP_CAP_DR;
			jip_pkg::JIP_CAP_DR: st_nxt = tms_q ? jip_pkg::JIP_EX1_DR
			                                    : jip_pkg::JIP_SH_DR;
			jip_pkg::JIP_SH_DR:  st_nxt = tms_q ? jip_pkg::JIP_EX1_DR
			                                    : jip_pkg::JIP_SH_DR;
			jip_pkg::JIP_EX1_DR: st_nxt = tms_q ? jip_pkg::JIP_UPD_DR
			                                    : jip_pkg::JIP_PAU_DR;
			jip_pkg::JIP_PAU_DR: st_nxt = tms_q ? jip_pkg::JIP_EX2_DR
			                                    : jip_pkg::JIP_PAU_DR;
			jip_pkg::JIP_EX2_DR: st_nxt = tms_q ? jip_pkg::JIP_UPD_DR
			                                    : jip_pkg::JIP_SH_DR;
			jip_pkg::JIP_UPD_DR: st_nxt = tms_q ? jip_pkg::JIP_SEL_DR
			                                    : jip_pkg::JIP_IDLE;
			jip_pkg::JIP_SEL_IR: st_nxt = tms_q ? jip_pkg::JIP_RESET
			                                    : jip_pkg::JIP_CAP_IR;
			jip_pkg::JIP_CAP_IR: st_nxt = tms_q ? jip_pkg::JIP_EX1_IR
			                                    : jip_pkg::JIP_SH_IR;
			jip_pkg::JIP_SH_IR:  st_nxt = tms_q ? jip_pkg::JIP_EX1_IR
			                                    : jip_pkg::JIP_SH_IR;
			jip_pkg::JIP_EX1_IR: st_nxt = tms_q ? jip_pkg::JIP_UPD_IR
			                                    : jip_pkg::JIP_PAU_IR;
			jip_pkg::JIP_PAU_IR: st_nxt = tms_q ? jip_pkg::JIP_EX2_IR
			                                    : jip_pkg::JIP_PAU_IR;
			jip_pkg::JIP_EX2_IR: st_nxt = tms_q ? jip_pkg::JIP_UPD_IR
			                                    : jip_pkg::JIP_SH_IR;
			jip_pkg::JIP_UPD_IR: st_nxt = tms_q ? jip_pkg::JIP_SEL_DR
			                                    : jip_pkg::JIP_IDLE;
			default:             st_nxt = jip_pkg::JIP_RESET;
		endcase
	end

	// state advances on each test clock rise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) st_r <= jip_pkg::JIP_RESET;
		else if (!trst_q) st_r <= jip_pkg::JIP_RESET;
		else if (rise) st_r <= st_nxt;
	end

	// instruction shift and current instruction
	logic [jip_pkg::IR_W-1:0] ir_sh_r; // shift stage
	logic [jip_pkg::IR_W-1:0] ir_r;    // current instruction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ir_sh_r <= jip_pkg::IR_CAPTURE;
			ir_r    <= jip_pkg::IR_IDCODE;
		end else if (st_r == jip_pkg::JIP_RESET) begin
			ir_r <= jip_pkg::IR_IDCODE;
		end else if (rise) begin
			if (st_r == jip_pkg::JIP_CAP_IR) ir_sh_r <= jip_pkg::IR_CAPTURE;
			else if (st_r == jip_pkg::JIP_SH_IR)
				ir_sh_r <= {tdi_q, ir_sh_r[3:1]};
		end else if (fall && st_r == jip_pkg::JIP_UPD_IR) begin
			ir_r <= ir_sh_r;
		end
	end

	// identification register selected by the current instruction
	logic id_sel;
	assign id_sel = (ir_r == jip_pkg::IR_IDCODE);

	// data registers: identification shifts in ones, bypass one bit
	logic [jip_pkg::ID_W-1:0] id_sh_r;
	logic                     byp_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			id_sh_r <= jip_pkg::ID_VALUE;
			byp_r   <= jip_pkg::BYP_RST;
		end else if (rise) begin
			if (st_r == jip_pkg::JIP_CAP_DR) begin
				id_sh_r <= jip_pkg::ID_VALUE;
				byp_r   <= 1'h0;
			end else if (st_r == jip_pkg::JIP_SH_DR) begin
				if (id_sel) id_sh_r <= {1'h1, id_sh_r[31:1]};
				else byp_r <= tdi_q;
			end
		end
	end

	// serial output changes on test clock fall
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tdo    <= jip_pkg::TDO_RST;
			tdo_oe <= jip_pkg::OE_RST;
		end else if (fall) begin
			tdo_oe <= (st_r == jip_pkg::JIP_SH_DR)
			       || (st_r == jip_pkg::JIP_SH_IR);
			if (st_r == jip_pkg::JIP_SH_IR) tdo <= ir_sh_r[0];
			else if (id_sel) tdo <= id_sh_r[0];
			else tdo <= byp_r;
		end
	end

	// status outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			id_sel_r <= jip_pkg::SEL_RST;
			tlr_r    <= jip_pkg::TLR_RST;
		end else begin
			id_sel_r <= id_sel;
			tlr_r    <= (st_r == jip_pkg::JIP_RESET);
		end
	end

	// reset state restores the default instruction
	AST_RESET_ID: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == jip_pkg::JIP_RESET) |=> (ir_r == jip_pkg::IR_IDCODE))
		else $error("reset state did not select identification");

	// identification shift takes a one at the top, never serial input
	AST_ONES_IN: assert property (@(posedge sys_clk) disable iff (rst)
		(rise && st_r == jip_pkg::JIP_SH_DR && id_sel) |=> id_sh_r[31])
		else $error("identification shift did not take a one");

	// capture always reloads the fixed identification value
	AST_ID_RO: assert property (@(posedge sys_clk) disable iff (rst)
		(rise && st_r == jip_pkg::JIP_CAP_DR)
		|=> (id_sh_r == jip_pkg::ID_VALUE))
		else $error("identification capture value changed");

	// bypass bit takes the serial input on each shift
	AST_BYP: assert property (@(posedge sys_clk) disable iff (rst)
		(rise && st_r == jip_pkg::JIP_SH_DR && !id_sel)
		|=> (byp_r == $past(tdi_q)))
		else $error("bypass bit did not take serial input");

	// test reset pin forces the reset state
	AST_TRST: assert property (@(posedge sys_clk) disable iff (rst)
		!trst_q |=> (st_r == jip_pkg::JIP_RESET))
		else $error("test reset did not force reset state");

	// identification low bit reaches the serial output at the fall
	AST_TDO_ID: assert property (@(posedge sys_clk) disable iff (rst)
		(fall && st_r == jip_pkg::JIP_SH_DR && id_sel)
		|=> (tdo == $past(id_sh_r[0])))
		else $error("serial output did not show identification bit");

	// bypass bit reaches the serial output at the fall
	AST_TDO_BYP: assert property (@(posedge sys_clk) disable iff (rst)
		(fall && st_r == jip_pkg::JIP_SH_DR && !id_sel)
		|=> (tdo == $past(byp_r)))
		else $error("serial output did not show bypass bit");

	// instruction update at the fall copies the shifted opcode
	AST_IR_UPD: assert property (@(posedge sys_clk) disable iff (rst)
		(fall && st_r == jip_pkg::JIP_UPD_IR)
		|=> (ir_r == $past(ir_sh_r)))
		else $error("instruction update did not take shifted opcode");

	// serial output driven through each shift state
	AST_OE_SHIFT: assert property (@(posedge sys_clk) disable iff (rst)
		(fall && (st_r == jip_pkg::JIP_SH_DR || st_r == jip_pkg::JIP_SH_IR))
		|=> tdo_oe)
		else $error("serial output not enabled while shifting");
endmodule // jip_tap

// >>> verif/jip_ctl.sv
// partner: scan controller that drives the test port pins
module jip_ctl (
	// system
	input  wire logic sys_clk,
	// test port pins
	input  wire logic tdo,
	input  wire logic tdo_oe,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins idle, clock stands low between frames
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	// one tck period, tdo taken just before the rise
	task automatic step(input logic ms, input logic di, output logic q);
		tms <= ms;
		tdi <= di;
		repeat (6) @(posedge sys_clk);
		// a released output has no pull, so it is seen inverted
		q = tdo_oe ? tdo : !tdo;
		tck <= 1'h1;
		repeat (7) @(posedge sys_clk);
		tck <= 1'h0;
	endtask
	// walk states by a tms string, lsb first
	task automatic walk(input logic [7:0] seq, input int n);
		logic q;
		for (int i = 0; i < n; i++) begin
			step(seq[i], 1'h0, q);
		end
	endtask
	// idle, shift n bits, update, idle; no later-device loads
	task automatic scan(input logic ir, input logic [63:0] din, input int n,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		walk(8'h01, 2);
	endtask
endmodule // jip_ctl

// >>> verif/testbench.sv
// testbench: identification and bypass paths against a queue model
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe;
	logic        id_sel_r, tlr_r, byp;
	int          fails, num_checks, cyc, seed;
	logic [63:0] din, dout;
	logic [3:0]  ops [3] = '{jip_pkg::IR_EXTEST, jip_pkg::IR_BYPASS,
		jip_pkg::IR_IDCODE};
	jip_tap uut (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
		.id_sel_r(id_sel_r), .tlr_r(tlr_r));
	jip_ctl ctl (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
		.tms(tms), .tdi(tdi));
	// system clock
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// expected tdo stream: id then ones, or bypass bit then tdi
	function automatic logic [63:0] model(input logic byp,
		input logic [63:0] d, input int n);
		logic        q [$];
		logic [63:0] r;
		r = '0;
		if (byp) q.push_back(jip_pkg::BYP_RST);
		else for (int i = 0; i < 32; i++) q.push_back(jip_pkg::ID_VALUE[i]);
		for (int i = 0; i < n; i++) begin
			r[i] = q.pop_front();
			q.push_back(byp ? d[i] : 1'h1);
		end
		return r;
	endfunction
	// compare one result
	task automatic chk(input string what, input logic [63:0] e,
		input logic [63:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask
	// compare one status flag
	task automatic chk_flag(input string what, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %b seen %b", what, e, s);
		end
	endtask
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// hang guard: the full run needs about 3900 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			conclude();
		end
	end
	// main sequence
	initial begin
		seed = 68;
		fails = 0;
		num_checks = 0;
		trst_n = 1'h1;
		rst = 1'h1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		chk_flag("tlr", 1'h1, tlr_r);
		chk_flag("id_sel", 1'h1, id_sel_r);
		ctl.walk(8'h00, 1);
		for (int k = 0; k < 2; k++) begin
			din = {$random(seed), $random(seed)};
			ctl.scan(1'h0, din, 48, dout);
			chk("id_scan", model(1'h0, din, 48), dout);
		end
		chk_flag("oe_idle", 1'h0, tdo_oe);
		// every opcode, each loaded before scanning the chain
		foreach (ops[j]) begin
			byp = (ops[j] != jip_pkg::IR_IDCODE);
			ctl.scan(1'h1, 64'(ops[j]), 4, dout);
			chk("ir_cap", 64'(jip_pkg::IR_CAPTURE), dout);
			chk_flag("id_sel", !byp, id_sel_r);
			din = {$random(seed), $random(seed)};
			ctl.scan(1'h0, din, 40, dout);
			chk("dr_scan", model(byp, din, 40), dout);
		end
		// test reset pulse forces the reset state and default instruction
		ctl.scan(1'h1, 64'(jip_pkg::IR_BYPASS), 4, dout);
		chk_flag("id_sel", 1'h0, id_sel_r);
		trst_n <= 1'h0;
		repeat (8) @(posedge sys_clk);
		trst_n <= 1'h1;
		repeat (8) @(posedge sys_clk);
		chk_flag("tlr", 1'h1, tlr_r);
		chk_flag("id_sel", 1'h1, id_sel_r);
		// leave reset, load bypass, then five ones return to reset
		ctl.walk(8'h00, 1);
		ctl.scan(1'h1, 64'(jip_pkg::IR_BYPASS), 4, dout);
		chk_flag("tlr", 1'h0, tlr_r);
		ctl.walk(8'h1F, 5);
		chk_flag("tlr", 1'h1, tlr_r);
		chk_flag("id_sel", 1'h1, id_sel_r);
		conclude();
	end
endmodule // testbench
